// >>> src/tlih_defs.vh
// Register map, reset values and field positions of the interrupt handler
`ifndef TLIH_DEFS_VH
`define TLIH_DEFS_VH

// Group width and source count
`define TLIH_GRP_W 8
`define TLIH_SRC_N 24

// Register byte offsets on the bus
`define TLIH_OFF_HIGH_FLAGS 6'h00
`define TLIH_OFF_MID_FLAGS 6'h04
`define TLIH_OFF_LOW_FLAGS 6'h08
`define TLIH_OFF_HIGH_EN 6'h0c
`define TLIH_OFF_MID_EN 6'h10
`define TLIH_OFF_LOW_EN 6'h14
`define TLIH_OFF_TOP_NUM 6'h18
`define TLIH_OFF_SUMMARY 6'h1c
`define TLIH_OFF_IRQ_STATUS 6'h20
`define TLIH_OFF_IRQ_MASK 6'h24

// Reset values
`define TLIH_RST_FLAGS 8'h00
`define TLIH_RST_EN 8'h00
`define TLIH_RST_TOP_NUM 8'hff
`define TLIH_RST_IRQ 3'h0

// Level summary and interrupt status field positions
`define TLIH_BIT_LOW 0
`define TLIH_BIT_MID 1
`define TLIH_BIT_HIGH 2

// Number reported when nothing is pending
`define TLIH_NONE_PENDING 8'hff

`endif

// >>> src/tlih_edge_group.v
// One group of eight sources: edge detect, enable gate and write-one-to-clear flags
`timescale 1ns/1ns
`include "tlih_defs.vh"

module tlih_edge_group
(
  // Clock and reset
  input wire ref_clk,
  input wire sys_rst,
  // Sources and controls
  input wire [`TLIH_GRP_W-1:0] src,
  input wire [`TLIH_GRP_W-1:0] enables,
  input wire [`TLIH_GRP_W-1:0] clear_ones,
  // State
  output wire [`TLIH_GRP_W-1:0] flags,
  output wire [`TLIH_GRP_W-1:0] new_set
);

  reg [`TLIH_GRP_W-1:0] src_prev_reg;
  reg [`TLIH_GRP_W-1:0] flags_reg;

  genvar i;
  generate
    for (i = 0; i < `TLIH_GRP_W; i = i + 1)
    begin : g_bit
      // Same clock as the peripherals, so no synchroniser
      assign new_set[i] = src[i] & ~src_prev_reg[i] & enables[i];
      always @(posedge ref_clk)
      begin
        if (sys_rst)
        begin
          src_prev_reg[i] <= 1'b0;
          flags_reg[i] <= 1'b0;
        end
        else
        begin
          src_prev_reg[i] <= src[i];
          // Set wins over a clear in the same cycle
          flags_reg[i] <= (flags_reg[i] & ~clear_ones[i]) | new_set[i];
        end
      end
    end
  endgenerate

  assign flags = flags_reg;

endmodule // tlih_edge_group

// >>> src/tlih_prio_enc.v
// Finds the highest numbered pending source, all ones when none
`timescale 1ns/1ns
`include "tlih_defs.vh"

module tlih_prio_enc
(
  // Flags, source 23 at the top
  input wire [`TLIH_SRC_N-1:0] flags,
  // Result
  output reg [7:0] top_num
);

  integer k;

  always @*
  begin
    top_num = `TLIH_NONE_PENDING;
    // Ascending scan so the highest number is written last
    for (k = 0; k < `TLIH_SRC_N; k = k + 1)
    begin
      if (flags[k])
      begin
        top_num = k[7:0];
      end
    end
  end

endmodule // tlih_prio_enc

// >>> src/tlih_top.v
// Three-level interrupt handler with an Avalon-MM register slave
//
// Function
// - 24 sources in three groups of eight drive high, mid, low core requests.
// - High flag bits 7..0 hold sources 23..16, cleared by writing one.
// - Mid flag bits 7..0 hold sources 15..8, readable, reset zero.
// - Low flag bits 7..0 hold sources 7..0, readable, reset zero.
// - Writing one to a flag bit clears it; zero leaves it.
// - Reset clears every pending flag.
// - A flag sets on an enabled rising source edge and stays until cleared.
// - High enable register, read-write, reset zero, bits enable sources 23..16.
// - Mid enable register, read-write, reset zero, bits enable sources 15..8.
// - Low enable register, read-write, reset zero, bits enable sources 7..0.
// - Priority register gives highest pending number, all ones when none.
// - Summary bit 2 high, bit 1 mid, bit 0 low pending; bits 7..3 zero.
// - All sources are sampled on the fastest system clock.
// - A source edge reaches the core request one clock later.
// - Clearing a flag here does not withdraw a request the core holds.
//
// Chosen here: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ns
`include "tlih_defs.vh"

module tlih_top
(
  // Clock and reset
  input wire ref_clk,
  input wire sys_rst,
  // Interrupt sources from peripherals
  input wire [7:0] src_high,
  input wire [7:0] src_mid,
  input wire [7:0] src_low,
  // Core interrupt request inputs
  output wire core_request_high,
  output wire core_request_mid,
  output wire core_request_low,
  // Interrupt to the system
  output wire irq_out,
  // Avalon-MM slave
  input wire [5:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output wire [31:0] avs_readdata,
  output wire avs_waitrequest
);

  // Bus slave states
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_DONE = 2'b10;

  // Register index decode, used for reads and writes
  function [9:0] addr_hit;
    input [5:0] addr;
    begin
      addr_hit = 10'h000;
      case (addr)
        `TLIH_OFF_HIGH_FLAGS: addr_hit[0] = 1'b1;
        `TLIH_OFF_MID_FLAGS: addr_hit[1] = 1'b1;
        `TLIH_OFF_LOW_FLAGS: addr_hit[2] = 1'b1;
        `TLIH_OFF_HIGH_EN: addr_hit[3] = 1'b1;
        `TLIH_OFF_MID_EN: addr_hit[4] = 1'b1;
        `TLIH_OFF_LOW_EN: addr_hit[5] = 1'b1;
        `TLIH_OFF_TOP_NUM: addr_hit[6] = 1'b1;
        `TLIH_OFF_SUMMARY: addr_hit[7] = 1'b1;
        `TLIH_OFF_IRQ_STATUS: addr_hit[8] = 1'b1;
        `TLIH_OFF_IRQ_MASK: addr_hit[9] = 1'b1;
        default: addr_hit = 10'h000;
      endcase
    end
  endfunction

  // Write-one-to-clear strobe of one register; zero bits clear nothing
  function [7:0] w1c_bits;
    input sel;
    input [7:0] data;
    begin
      w1c_bits = sel ? data : 8'h00;
    end
  endfunction

  // Registers
  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [7:0] high_source_enables_reg;
  reg [7:0] mid_source_enables_reg;
  reg [7:0] low_source_enables_reg;
  reg [2:0] irq_status_reg;
  reg [2:0] irq_status_next;
  reg [2:0] irq_mask_reg;
  reg [2:0] irq_mask_next;
  reg irq_out_reg;
  reg core_request_high_reg;
  reg core_request_mid_reg;
  reg core_request_low_reg;
  reg [31:0] readdata_reg;
  reg [31:0] readdata_next;
  reg waitrequest_reg;

  // Group state
  wire [7:0] high_pending_flags;
  wire [7:0] mid_pending_flags;
  wire [7:0] low_pending_flags;
  wire [7:0] high_new;
  wire [7:0] mid_new;
  wire [7:0] low_new;
  wire [7:0] top_pending_number;
  wire [7:0] level_pending_summary;
  wire any_high_pending;
  wire any_mid_pending;
  wire any_low_pending;

  // Bus decode
  wire [9:0] hit;
  wire req;
  wire accept;
  wire wr_ok;
  wire [7:0] wbyte;
  wire [7:0] clr_high;
  wire [7:0] clr_mid;
  wire [7:0] clr_low;
  wire [2:0] new_level;

  assign hit = addr_hit(avs_address);
  assign req = avs_read | avs_write;
  // One access per request; the done cycle ignores the held request
  assign accept = req & state_reg[0];
  // Only the low byte carries data; byte lane 0 gates every write
  assign wr_ok = accept & avs_write & avs_byteenable[0];
  assign wbyte = avs_writedata[7:0];

  // Write-one-to-clear strobes
  // Read-only and unmapped offsets decode to no strobe, so such writes are dropped
  assign clr_high = w1c_bits(wr_ok & hit[0], wbyte);
  assign clr_mid = w1c_bits(wr_ok & hit[1], wbyte);
  assign clr_low = w1c_bits(wr_ok & hit[2], wbyte);

  // Sources 23..16
  tlih_edge_group u_high
  (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .src (src_high),
    .enables (high_source_enables_reg),
    .clear_ones (clr_high),
    .flags (high_pending_flags),
    .new_set (high_new)
  );

  // Sources 15..8
  tlih_edge_group u_mid
  (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .src (src_mid),
    .enables (mid_source_enables_reg),
    .clear_ones (clr_mid),
    .flags (mid_pending_flags),
    .new_set (mid_new)
  );

  // Sources 7..0
  tlih_edge_group u_low
  (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .src (src_low),
    .enables (low_source_enables_reg),
    .clear_ones (clr_low),
    .flags (low_pending_flags),
    .new_set (low_new)
  );

  // Source 23 sits at the top bit of the concatenation
  tlih_prio_enc u_prio
  (
    .flags ({high_pending_flags, mid_pending_flags, low_pending_flags}),
    .top_num (top_pending_number)
  );

  // Summary follows the flags directly, with no register stage
  assign any_high_pending = |high_pending_flags;
  assign any_mid_pending = |mid_pending_flags;
  assign any_low_pending = |low_pending_flags;
  assign level_pending_summary = {5'h00, any_high_pending, any_mid_pending, any_low_pending};

  // Any new flag in a level gives one request pulse and one status set
  assign new_level[`TLIH_BIT_HIGH] = |high_new;
  assign new_level[`TLIH_BIT_MID] = |mid_new;
  assign new_level[`TLIH_BIT_LOW] = |low_new;

  // Core requests: one-cycle pulse the edge after the source rose
  always @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      core_request_high_reg <= 1'b0;
      core_request_mid_reg <= 1'b0;
      core_request_low_reg <= 1'b0;
    end
    else
    begin
      // Pulse only; the core holds the request itself, so a flag clear cannot withdraw it
      core_request_high_reg <= new_level[`TLIH_BIT_HIGH];
      core_request_mid_reg <= new_level[`TLIH_BIT_MID];
      core_request_low_reg <= new_level[`TLIH_BIT_LOW];
    end
  end

  // Enable registers
  // Dropping an enable leaves an already set flag in place
  always @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      high_source_enables_reg <= `TLIH_RST_EN;
      mid_source_enables_reg <= `TLIH_RST_EN;
      low_source_enables_reg <= `TLIH_RST_EN;
    end
    else
    begin
      if (wr_ok & hit[3])
      begin
        high_source_enables_reg <= wbyte;
      end
      if (wr_ok & hit[4])
      begin
        mid_source_enables_reg <= wbyte;
      end
      if (wr_ok & hit[5])
      begin
        low_source_enables_reg <= wbyte;
      end
    end
  end

  // Interrupt status: new flag per level, write one to clear, set wins
  always @*
  begin
    irq_status_next = irq_status_reg;
    if (wr_ok & hit[8])
    begin
      irq_status_next = irq_status_reg & ~wbyte[2:0];
    end
    irq_status_next = irq_status_next | new_level;
  end

  always @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      irq_status_reg <= `TLIH_RST_IRQ;
      irq_mask_reg <= `TLIH_RST_IRQ;
    end
    else
    begin
      irq_status_reg <= irq_status_next;
      irq_mask_reg <= irq_mask_next;
    end
  end

  // Mask: plain read-write, same layout as the status
  always @*
  begin
    irq_mask_next = irq_mask_reg;
    if (wr_ok & hit[9])
    begin
      irq_mask_next = wbyte[2:0];
    end
  end

  // Built from the next status and mask: no lag behind them, yet straight from a flip-flop
  always @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      irq_out_reg <= 1'b0;
    end
    else
    begin
      irq_out_reg <= |(irq_status_next & irq_mask_next);
    end
  end

  // Read mux; unmapped addresses read zero
  // The word is held between reads, so it stands through the answer cycle
  always @*
  begin
    readdata_next = readdata_reg;
    if (accept & avs_read)
    begin
      readdata_next = 32'h00000000;
      case (1'b1)
        hit[0]: readdata_next[7:0] = high_pending_flags;
        hit[1]: readdata_next[7:0] = mid_pending_flags;
        hit[2]: readdata_next[7:0] = low_pending_flags;
        hit[3]: readdata_next[7:0] = high_source_enables_reg;
        hit[4]: readdata_next[7:0] = mid_source_enables_reg;
        hit[5]: readdata_next[7:0] = low_source_enables_reg;
        hit[6]: readdata_next[7:0] = top_pending_number;
        hit[7]: readdata_next[7:0] = level_pending_summary;
        hit[8]: readdata_next[2:0] = irq_status_reg;
        hit[9]: readdata_next[2:0] = irq_mask_reg;
        default: readdata_next = 32'h00000000;
      endcase
    end
  end

  // Bus handshake: take request, drop waitrequest for one cycle
  // The answer cycle ignores the still held request, so it is not taken twice
  always @*
  begin
    case (state_reg)
      ST_IDLE: state_next = req ? ST_DONE : ST_IDLE;
      ST_DONE: state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end

  always @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      state_reg <= ST_IDLE;
      readdata_reg <= 32'h00000000;
      waitrequest_reg <= 1'b1;
    end
    else
    begin
      state_reg <= state_next;
      readdata_reg <= readdata_next;
      // High at idle, so no answer shows without a request
      waitrequest_reg <= ~(state_next == ST_DONE);
    end
  end

  assign core_request_high = core_request_high_reg;
  assign core_request_mid = core_request_mid_reg;
  assign core_request_low = core_request_low_reg;
  assign irq_out = irq_out_reg;
  assign avs_readdata = readdata_reg;
  assign avs_waitrequest = waitrequest_reg;

endmodule // tlih_top

// >>> dv/tlih_core_model.sv
// Behavioural core: memorises level requests and picks the one to service
`timescale 1ns/1ns
module tlih_core_model
(
  // Clock and reset
  input wire ref_clk,
  input wire sys_rst,
  // Requests, and the core's own clears with bit 0 the high level
  input wire req_high,
  input wire req_mid,
  input wire req_low,
  input wire [2:0] clr,
  // Memorised levels and level in service, 3 when idle
  output reg [2:0] pend_reg,
  output wire [1:0] serve
);
  // Only the core's own clear or reset ends a memorised request
  always @(posedge ref_clk)
    pend_reg <= sys_rst ? 3'h0 : (pend_reg & ~clr) | {req_low, req_mid, req_high};
  assign serve = pend_reg[0] ? 2'h0 : pend_reg[1] ? 2'h1 : pend_reg[2] ? 2'h2 : 2'h3;
endmodule // tlih_core_model

// >>> dv/tlih_top_assertions.sv
// Port-level assertions for the interrupt handler top
`timescale 1ns/1ns
module tlih_top_assertions
(
  // Clock and reset
  input wire ref_clk,
  input wire sys_rst,
  // Sources, core requests and the system interrupt
  input wire [7:0] src_high,
  input wire [7:0] src_mid,
  input wire [7:0] src_low,
  input wire core_request_high,
  input wire core_request_mid,
  input wire core_request_low,
  input wire irq_out,
  // Register bus
  input wire [5:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  sequence s_taken;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_answer;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  a_req_high: assert property (core_request_high |-> |($past(src_high) & ~$past(src_high, 2)))
    else $error("high request without a source edge");
  a_req_mid: assert property (core_request_mid |-> |($past(src_mid) & ~$past(src_mid, 2)))
    else $error("mid request without a source edge");
  a_req_low: assert property (core_request_low |-> |($past(src_low) & ~$past(src_low, 2)))
    else $error("low request without a source edge");
  a_req_pulse: assert property (core_request_high && !(|(src_high & ~$past(src_high))) |=> !core_request_high)
    else $error("high request longer than one cycle");
  a_wait_one: assert property (s_taken |=> s_answer)
    else $error("bus answer not exactly one cycle");
  a_idle_wait: assert property (!(avs_read || avs_write) |=> avs_waitrequest)
    else $error("waitrequest low without a request");
  // Own disable, the default would mask the reset itself
  a_rst_quiet: assert property (disable iff (1'b0) sys_rst |=> avs_waitrequest && !irq_out && !core_request_high)
    else $error("outputs active after reset");
  a_sum_bits: assert property (avs_read && !avs_waitrequest && avs_address == 6'h1c |-> avs_readdata[31:3] == 29'h0)
    else $error("summary upper bits not zero");
  a_data_width: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
    else $error("read data above bit 7 not zero");
  a_irq_rise: assert property ($rose(irq_out) |-> core_request_high || core_request_mid || core_request_low
    || $past(avs_write))
    else $error("interrupt rose without a cause");
endmodule // tlih_top_assertions

bind tlih_top tlih_top_assertions u_tlih_top_assertions (.ref_clk(ref_clk), .sys_rst(sys_rst),
  .src_high(src_high), .src_mid(src_mid), .src_low(src_low), .core_request_high(core_request_high),
  .core_request_mid(core_request_mid), .core_request_low(core_request_low), .irq_out(irq_out),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest));

// >>> dv/test_three_level_irq_handler.sv
// Self-checking bench for the three-level interrupt handler
`timescale 1ns/1ns
module test_three_level_irq_handler;
  reg ref_clk = 1'b0;
  reg sys_rst = 1'b1;
  reg [7:0] src_high = 8'h00, src_mid = 8'h00, src_low = 8'h00;
  reg [5:0] adr = 6'h00;
  reg rd_en = 1'b0, wr_en = 1'b0;
  reg [31:0] wdat = 32'h0, got;
  reg [2:0] core_clr = 3'h0;
  reg [3:0] be = 4'h1;
  wire [31:0] rdat;
  wire wreq, req_h, req_m, req_l, irq;
  wire [2:0] core_pend;
  wire [1:0] core_serve;
  integer n_fail = 0, checked = 0, i;
  always #5 ref_clk = ~ref_clk;
  tlih_top u_tlih_top (.ref_clk(ref_clk), .sys_rst(sys_rst), .src_high(src_high), .src_mid(src_mid),
    .src_low(src_low), .core_request_high(req_h), .core_request_mid(req_m), .core_request_low(req_l),
    .irq_out(irq), .avs_address(adr), .avs_read(rd_en), .avs_write(wr_en), .avs_writedata(wdat),
    .avs_byteenable(be), .avs_readdata(rdat), .avs_waitrequest(wreq));
  tlih_core_model u_tlih_core_model (.ref_clk(ref_clk), .sys_rst(sys_rst), .req_high(req_h),
    .req_mid(req_m), .req_low(req_l), .clr(core_clr), .pend_reg(core_pend), .serve(core_serve));
  task end_sim;
    begin
      $display("checked=%0d n_fail=%0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      checked = checked + 1;
      if (g !== e)
      begin
        n_fail = n_fail + 1;
        $display("[FAIL] %0s exp=%h got=%h", nm, e, g);
      end
    end
  endtask
  // Holds the request until waitrequest is sampled low
  task bus(input w, input [5:0] a, input [7:0] d);
    integer k;
    begin
      @(posedge ref_clk);
      adr <= a;
      wdat <= {24'h0, d};
      rd_en <= ~w;
      wr_en <= w;
      for (k = 0; k < 20 && wreq !== 1'b0; k = k + 1)
        @(posedge ref_clk);
      if (k == 20)
      begin
        n_fail = n_fail + 1;
        end_sim;
      end
      got = rdat;
      rd_en <= 1'b0;
      wr_en <= 1'b0;
    end
  endtask
  task rc(input [5:0] a, input [31:0] e, input string nm);
    begin
      bus(1'b0, a, 8'h00);
      chk(nm, e, got);
    end
  endtask
  // One-cycle source pulse; request expected in the following cycle
  task pulse(input integer n, input en);
    begin
      @(posedge ref_clk);
      {src_high, src_mid, src_low} <= 24'h1 << n;
      @(posedge ref_clk);
      {src_high, src_mid, src_low} <= 24'h0;
      #1;
      chk("core_req", en ? 32'h1 << (n / 8) : 32'h0, {req_h, req_m, req_l});
    end
  endtask
  task irq_is(input e);
    begin
      @(posedge ref_clk);
      #1;
      chk("irq_out", e, irq);
    end
  endtask
  initial
  begin
    repeat (5) @(posedge ref_clk);
    sys_rst <= 1'b0;
    for (i = 0; i < 10; i = i + 1)
      rc({i[3:0], 2'b00}, i == 6 ? 32'hff : 32'h0, "reset_val");
    rc(6'h28, 32'h0, "unmapped");
    for (i = 0; i < 24; i = i + 1)
      pulse(i, 1'b0);
    for (i = 0; i < 3; i = i + 1)
      rc({i[3:0], 2'b00}, 32'h0, "flag_off");
    for (i = 3; i < 6; i = i + 1)
    begin
      bus(1'b1, {i[3:0], 2'b00}, 8'h5a + i);
      rc({i[3:0], 2'b00}, 8'h5a + i, "enable_rw");
      bus(1'b1, {i[3:0], 2'b00}, 8'hff);
    end
    // Byte lane 0 off: the write is dropped
    be <= 4'h0;
    bus(1'b1, 6'h0c, 8'h00);
    be <= 4'h1;
    rc(6'h0c, 32'hff, "be_off");
    bus(1'b1, 6'h18, 8'h00);
    rc(6'h18, 32'hff, "top_ro");
    // Ascending order makes each new source the top one
    for (i = 0; i < 24; i = i + 1)
    begin
      pulse(i, 1'b1);
      rc(6'h18, i, "top_num");
      rc(6'h1c, (i < 8) ? 32'h1 : (i < 16) ? 32'h3 : 32'h7, "summary");
    end
    bus(1'b1, 6'h00, 8'h0f);
    bus(1'b1, 6'h00, 8'h00);
    rc(6'h00, 32'hf0, "high_flags");
    rc(6'h04, 32'hff, "mid_flags");
    rc(6'h08, 32'hff, "low_flags");
    bus(1'b1, 6'h00, 8'hf0);
    rc(6'h18, 32'hf, "top_mid");
    rc(6'h1c, 32'h3, "sum_mid");
    bus(1'b1, 6'h04, 8'hff);
    bus(1'b1, 6'h08, 8'hff);
    rc(6'h18, 32'hff, "top_none");
    rc(6'h1c, 32'h0, "sum_none");
    chk("core_pend", 32'h7, core_pend);
    chk("core_serve", 32'h0, core_serve);
    @(posedge ref_clk);
    core_clr <= 3'h1;
    @(posedge ref_clk);
    core_clr <= 3'h0;
    #1;
    chk("core_next", 32'h1, core_serve);
    bus(1'b1, 6'h20, 8'h07);
    rc(6'h20, 32'h0, "irq_status");
    bus(1'b1, 6'h24, 8'h02);
    rc(6'h24, 32'h2, "irq_mask");
    pulse(8, 1'b1);
    irq_is(1'b1);
    bus(1'b1, 6'h24, 8'h00);
    irq_is(1'b0);
    bus(1'b1, 6'h24, 8'h02);
    irq_is(1'b1);
    bus(1'b1, 6'h20, 8'h02);
    irq_is(1'b0);
    rc(6'h20, 32'h0, "status_clr");
    // Reset in mid-run with flags pending
    pulse(23, 1'b1);
    rc(6'h18, 32'h17, "top_high");
    @(posedge ref_clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rc(6'h00, 32'h0, "rst_high");
    rc(6'h04, 32'h0, "rst_mid");
    rc(6'h18, 32'hff, "rst_top");
    rc(6'h10, 32'h0, "rst_en");
    end_sim;
  end
endmodule // test_three_level_irq_handler
